// ---- bench/host_bus_model.sv ----
// host cpu model: avalon-mm master on the register bus
`timescale 1ns/1ps
module host_bus_model (
  // clock
  input  wire logic        sys_clk,
  // avalon-mm master side
  output logic      [5:0]  avsAddress,
  output logic             avsRead,
  output logic             avsWrite,
  output logic      [31:0] avsWritedata,
  output logic      [3:0]  avsByteenable,
  input  wire logic [31:0] avsReaddata,
  input  wire logic        avsWaitrequest
);
  // idle bus at time zero
  initial begin
    avsAddress    = 6'h3f;
    avsRead       = 1'b0;
    avsWrite      = 1'b0;
    avsWritedata  = 32'hffffffff;
    avsByteenable = 4'h1;
  end

  // one access: request held until waitrequest is sampled low
  task automatic access(input logic wr, input logic [5:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic ok);
    int n;
    @(posedge sys_clk);
    avsAddress   <= addr;
    avsRead      <= ~wr;
    avsWrite     <= wr;
    avsWritedata <= {24'h000000, wdata};
    n = 0;
    // bounded wait, the caller ends the run on a hang
    do begin
      @(posedge sys_clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 64);
    ok    = (avsWaitrequest === 1'b0);
    rdata = avsReaddata[7:0];
    // released address and data show the inverse, never the last value; read and write drop low
    avsRead      <= 1'b0;
    avsWrite     <= 1'b0;
    avsAddress   <= ~addr;
    avsWritedata <= ~{24'h000000, wdata};
  endtask : access
endmodule : host_bus_model

// ---- bench/uart_interrupt_identify_bench.sv ----
// self-checking bench of the interrupt identification block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checksDone++; if ((got) !== (exp)) begin failCount++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module uart_interrupt_identify_bench;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic                           sys_clk;
  logic                           rst_n;
  logic [5:0]                     avsAddress;
  logic                           avsRead;
  logic                           avsWrite;
  logic [31:0]                    avsWritedata;
  logic [3:0]                     avsByteenable;
  logic [31:0]                    avsReaddata;
  logic                           avsWaitrequest;
  uart_irq_pkg::chanSrc_s [1:0]   src;          // source generator stand-ins
  logic [1:0]                     ctsPin;       // cts pins
  logic [1:0]                     irqOutput;    // interrupt outputs
  int                             failCount;    // mismatches
  int                             checksDone;   // comparisons
  localparam logic [7:0]          fifoOn = {uart_irq_pkg::FIFO_ON, 6'h00};

  uart_interrupt_identify uart_interrupt_identify_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .srcIn(src),
    .ctsPin(ctsPin), .irqOutput(irqOutput));

  host_bus_model host_bus_model_inst (
    .sys_clk(sys_clk), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest));

  // 40 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  // bus access through the host model; a hang ends the run
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    logic ok;
    host_bus_model_inst.access(wr, a, d, q, ok);
    if (!ok) begin
      failCount++;
      $display("CHECK FAILED waitrequest expected 0 seen 1");
      wrap_up();
    end
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdChk(input string nm, input logic [5:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(nm, e, q)
  endtask : rdChk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // reset values, unmapped place, fifo status bits
  task automatic testReset;
    rdChk("ident0", 6'h08, 8'h01);
    rdChk("enable0", 6'h04, 8'h00);
    rdChk("enh0", 6'h0c, 8'h00);
    rdChk("unmapped", 6'h10, 8'h00);
    wr(6'h08, 8'h01);
    rdChk("identFifo", 6'h08, 8'h01 | fifoOn);
    $display("testReset done");
  endtask : testReset

  // all low sources at once, walked down by their clearing accesses and by dropping the trigger level
  task automatic testWalk;
    wr(6'h04, 8'h0f);
    @(posedge sys_clk);
    src[0].lineStatus  <= 8'h02;
    src[0].rxTimeout   <= 1'b1;
    src[0].rxTrig      <= 1'b1;
    src[0].txEmpty     <= 1'b1;
    src[0].modemStatus <= 8'h01;
    @(posedge sys_clk);
    src[0].rxTimeout   <= 1'b0;
    src[0].modemStatus <= 8'h00;
    tick(3);
    `CHK("irq0", 1'b1, irqOutput[0])
    rdChk("line", 6'h08, 8'h06 | fifoOn);
    rdChk("lsr", 6'h14, 8'h02);
    rdChk("tout", 6'h08, 8'h0c | fifoOn);
    rdChk("rbr", 6'h00, 8'h00);
    rdChk("rxdv", 6'h08, 8'h04 | fifoOn);
    rdChk("rxdv2", 6'h08, 8'h04 | fifoOn);
    src[0].rxTrig <= 1'b0;
    tick(2);
    rdChk("thre", 6'h08, 8'h02 | fifoOn);
    rdChk("modem", 6'h08, 8'h00 | fifoOn);
    rdChk("modem2", 6'h08, 8'h00 | fifoOn);
    rdChk("msr", 6'h18, 8'h00);
    src[0].lineStatus <= 8'h06;
    tick(2);
    rdChk("lineAgain", 6'h08, 8'h06 | fifoOn);
    src[0].lineStatus <= 8'h00;
    tick(3);
    rdChk("none", 6'h08, 8'h01 | fifoOn);
    `CHK("irq0off", 1'b0, irqOutput[0])
    $display("testWalk done");
  endtask : testWalk

  // xoff, special character, rts and cts sources
  task automatic testFlow;
    wr(6'h04, 8'he0);
    @(posedge sys_clk);
    src[0].xoffSeen <= 1'b1;
    @(posedge sys_clk);
    src[0].xoffSeen <= 1'b0;
    tick(3);
    `CHK("irqGated", 1'b0, irqOutput[0])
    rdChk("gated", 6'h08, 8'h01 | fifoOn);
    wr(6'h0c, 8'h10);
    @(posedge sys_clk);
    src[0].xoffSeen <= 1'b1;
    @(posedge sys_clk);
    src[0].xoffSeen <= 1'b0;
    tick(2);
    rdChk("xoff", 6'h08, 8'h10 | fifoOn);
    rdChk("xoffClr", 6'h08, 8'h01 | fifoOn);
    src[0].xoffSeen <= 1'b1;
    @(posedge sys_clk);
    src[0].xoffSeen <= 1'b0;
    tick(3);
    `CHK("irqXoff", 1'b1, irqOutput[0])
    src[0].xonSeen  <= 1'b1;
    @(posedge sys_clk);
    src[0].xonSeen  <= 1'b0;
    tick(3);
    `CHK("xonClr", 1'b0, irqOutput[0])
    src[0].specialSeen <= 1'b1;
    @(posedge sys_clk);
    src[0].specialSeen <= 1'b0;
    tick(3);
    `CHK("irqSpec", 1'b1, irqOutput[0])
    src[0].charSeen    <= 1'b1;
    @(posedge sys_clk);
    src[0].charSeen    <= 1'b0;
    tick(3);
    `CHK("charClr", 1'b0, irqOutput[0])
    src[0].autoRts     <= 1'b1;
    src[0].rtsOut      <= 1'b1;
    tick(2);
    rdChk("rts", 6'h08, 8'h20 | fifoOn);
    rdChk("msrClr", 6'h18, 8'h00);
    rdChk("rtsClr", 6'h08, 8'h01 | fifoOn);
    src[0].rtsOut <= 1'b0;
    tick(2);
    src[0].rtsOut <= 1'b1;
    tick(3);
    `CHK("irqRts", 1'b1, irqOutput[0])
    rdChk("msrRts", 6'h18, 8'h00);
    tick(2);
    `CHK("rtsMsrClr", 1'b0, irqOutput[0])
    src[0].autoCts <= 1'b1;
    ctsPin[0]      <= 1'b1;
    tick(6);
    rdChk("cts", 6'h08, 8'h20 | fifoOn);
    rdChk("ctsClr", 6'h08, 8'h01 | fifoOn);
    $display("testFlow done");
  endtask : testFlow

  // masking per channel, channel independence, holding register write
  task automatic testMask;
    src[1].lineStatus <= 8'h10;
    tick(3);
    `CHK("irq1Masked", 1'b0, irqOutput[1])
    rdChk("ident1", 6'h28, 8'h01);
    wr(6'h24, 8'h04);
    tick(3);
    `CHK("irq1", 1'b1, irqOutput[1])
    `CHK("irq0Quiet", 1'b0, irqOutput[0])
    rdChk("ident1Line", 6'h28, 8'h06);
    src[1].lineStatus <= 8'h00;
    src[0].txEmpty    <= 1'b0;
    wr(6'h04, 8'h02);
    src[0].txEmpty    <= 1'b1;
    tick(3);
    `CHK("irqThre", 1'b1, irqOutput[0])
    wr(6'h00, 8'h5a);
    tick(2);
    rdChk("threClr", 6'h08, 8'h01 | fifoOn);
    $display("testMask done");
  endtask : testMask

  // a source rising during an identification read is held back
  task automatic testFreeze;
    logic [7:0] q;
    wr(6'h04, 8'h04);
    fork
      bus(1'b0, 6'h08, 8'h00, q);
      begin
        tick(2);
        src[0].lineStatus <= 8'h08;
      end
    join
    `CHK("frozen", 8'h01 | fifoOn, q)
    tick(2);
    rdChk("captured", 6'h08, 8'h06 | fifoOn);
    src[0].lineStatus <= 8'h00;
    $display("testFreeze done");
  endtask : testFreeze

  // main sequence: reset for three cycles, then the scenarios
  initial begin
    failCount  = 0;
    checksDone = 0;
    rst_n      = 1'b0;
    src        = '0;
    ctsPin     = 2'h0;
    tick(3);
    rst_n <= 1'b1;
    testReset();
    testWalk();
    testFlow();
    testMask();
    testFreeze();
    wrap_up();
  end
endmodule : uart_interrupt_identify_bench

// ---- core/uart_interrupt_identify.sv ----
// two-channel interrupt prioritisation and identification with avalon slave
`timescale 1ns/1ps
module uart_interrupt_identify (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  // avalon-mm slave
  input  wire logic [5:0]               avsAddress,
  input  wire logic                     avsRead,
  input  wire logic                     avsWrite,
  input  wire logic [31:0]              avsWritedata,
  input  wire logic [3:0]               avsByteenable,
  output logic      [31:0]              avsReaddata,
  output logic                          avsWaitrequest,
  // source generators, one entry per channel
  input  wire uart_irq_pkg::chanSrc_s [1:0] srcIn,
  input  wire logic [1:0]               ctsPin,
  // interrupt outputs, one per channel
  output logic      [1:0]               irqOutput
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    uart_irq_pkg::chan_s [1:0] ch;  // per-channel state
    logic                      busy;  // second cycle of an access
    logic [7:0]                rdata; // captured read data
  } state_s;

  state_s     state;                  // registered state
  state_s     next_state;             // next value
  logic [7:0] identNow [2];           // live identification value
  logic [6:0] pend     [2];           // enabled pending sources
  logic       done;                   // access completes this edge
  logic       first;                  // first cycle of an access
  logic       selCh;                  // addressed channel
  logic [2:0] idx;                    // addressed register index
  logic       aligned;                // low address bits zero

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  assign selCh   = avsAddress[5];
  assign idx     = avsAddress[4:2];
  assign aligned = (avsAddress[1:0] == 2'h0);
  assign first   = (avsRead | avsWrite) & ~state.busy;
  assign done    = (avsRead | avsWrite) & state.busy;

  // every access stalls one cycle so that the read value is frozen
  assign avsWaitrequest = first;
  assign avsReaddata    = {24'h000000, state.rdata};
  assign irqOutput      = {state.ch[1].irq, state.ch[0].irq};

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic       enh;
    logic       mine;
    logic       rdIdent;
    logic       rdLsr;
    logic       rdMsr;
    logic       rdBuf;
    logic       wrHold;
    logic       wrOk;
    logic [3:0] errRise;
    logic       ctsRise;
    logic       rtsRise;
    logic [5:0] shown;
    enh     = 1'b0;
    mine    = 1'b0;
    rdIdent = 1'b0;
    rdLsr   = 1'b0;
    rdMsr   = 1'b0;
    rdBuf   = 1'b0;
    wrHold  = 1'b0;
    wrOk    = 1'b0;
    errRise = 4'h0;
    ctsRise = 1'b0;
    rtsRise = 1'b0;
    shown   = 6'h00;
    next_state = state;
    next_state.busy = first;

    for (int c = 0; c < uart_irq_pkg::NUM_CHAN; c++) begin
      // gating of the enhanced enables
      // RULE25: enhanced bit gate
      enh = state.ch[c].enhanced_feature_reg[uart_irq_pkg::EFR_ENH];

      // masked sources, status flags keep running underneath
      // RULE23: enable masking
      // RULE15: line errors level
      pend[c][0] = state.ch[c].interrupt_enable_reg[uart_irq_pkg::IER_LINE]
                   & (|srcIn[c].lineStatus[4:1]) & ~state.ch[c].lineAck;
      pend[c][1] = state.ch[c].interrupt_enable_reg[uart_irq_pkg::IER_RXDV] & state.ch[c].tout;
      // RULE16: trigger level pending
      pend[c][2] = state.ch[c].interrupt_enable_reg[uart_irq_pkg::IER_RXDV] & srcIn[c].rxTrig;
      pend[c][3] = state.ch[c].interrupt_enable_reg[uart_irq_pkg::IER_THRE] & state.ch[c].thre;
      pend[c][4] = state.ch[c].interrupt_enable_reg[uart_irq_pkg::IER_MODM] & state.ch[c].modem;
      pend[c][5] = state.ch[c].interrupt_enable_reg[uart_irq_pkg::IER_XOFF] & enh
                   & state.ch[c].xoff;
      pend[c][6] = enh & ((state.ch[c].interrupt_enable_reg[uart_irq_pkg::IER_CTS] & state.ch[c].cts)
                   | (state.ch[c].interrupt_enable_reg[uart_irq_pkg::IER_RTS] & state.ch[c].rts));

      // priority encoder, lowest index wins
      // RULE1: seven level ranking
      // RULE26: highest pending shown
      if (pend[c][0]) begin
        // RULE8: line status code
        shown = uart_irq_pkg::ID_LINE;
      end else if (pend[c][1]) begin
        // RULE9: time-out code
        shown = uart_irq_pkg::ID_TOUT;
      end else if (pend[c][2]) begin
        // RULE10: data ready code
        shown = uart_irq_pkg::ID_RXDV;
      end else if (pend[c][3]) begin
        // RULE11: holding empty code
        shown = uart_irq_pkg::ID_THRE;
      end else if (pend[c][4]) begin
        // RULE12: modem status code
        shown = uart_irq_pkg::ID_MODM;
      end else if (pend[c][5]) begin
        // RULE13: xoff code
        // RULE6: bit 4 flag
        shown = uart_irq_pkg::ID_XOFF;
      end else if (pend[c][6]) begin
        // RULE14: flow edge code
        // RULE5: bit 5 flag
        shown = uart_irq_pkg::ID_FLOW;
      end else begin
        // RULE7: nothing pending
        shown = uart_irq_pkg::ID_NONE;
      end
      // RULE4: fifo status bits
      identNow[c] = {state.ch[c].fifoOn ? uart_irq_pkg::FIFO_ON
                                        : uart_irq_pkg::FIFO_OFF, shown};

      // completing accesses addressed to this channel
      mine    = done & aligned & (selCh == c[0]);
      wrOk    = mine & avsWrite & avsByteenable[0];
      rdIdent = mine & avsRead & (idx == uart_irq_pkg::IDX_IDENT);
      rdLsr   = mine & avsRead & (idx == uart_irq_pkg::IDX_LSR);
      rdMsr   = mine & avsRead & (idx == uart_irq_pkg::IDX_MSR);
      rdBuf   = mine & avsRead & (idx == uart_irq_pkg::IDX_RXBUF);
      wrHold  = wrOk & (idx == uart_irq_pkg::IDX_RXBUF);

      // software registers
      if (wrOk && idx == uart_irq_pkg::IDX_IER) begin
        next_state.ch[c].interrupt_enable_reg = avsWritedata[7:0];
      end
      if (wrOk && idx == uart_irq_pkg::IDX_EFR) begin
        next_state.ch[c].enhanced_feature_reg = avsWritedata[7:0];
      end
      if (wrOk && idx == uart_irq_pkg::IDX_IDENT) begin
        next_state.ch[c].fifoOn = avsWritedata[uart_irq_pkg::FCR_FIFO];
      end

      // line status: ack by read, re-armed by any new error
      // RULE15: line read clears
      errRise = srcIn[c].lineStatus[4:1] & ~state.ch[c].errPrev;
      next_state.ch[c].errPrev = srcIn[c].lineStatus[4:1];
      if (errRise != 4'h0 || srcIn[c].lineStatus[4:1] == 4'h0) begin
        next_state.ch[c].lineAck = 1'b0;
      end else if (rdLsr) begin
        next_state.ch[c].lineAck = 1'b1;
      end

      // receive time-out, set wins over the buffer read
      // RULE17: time-out flag
      if (srcIn[c].rxTimeout) begin
        next_state.ch[c].tout = 1'b1;
      end else if (rdBuf) begin
        next_state.ch[c].tout = 1'b0;
      end

      // holding empty on rising empty level
      // RULE18: holding empty flag
      next_state.ch[c].txPrev = srcIn[c].txEmpty;
      if (srcIn[c].txEmpty && !state.ch[c].txPrev) begin
        next_state.ch[c].thre = 1'b1;
      end else if (wrHold || (rdIdent && state.rdata[5:0] == uart_irq_pkg::ID_THRE)) begin
        next_state.ch[c].thre = 1'b0;
      end

      // modem deltas
      // RULE19: modem flag
      if (srcIn[c].modemStatus[3:0] != 4'h0) begin
        next_state.ch[c].modem = 1'b1;
      end else if (rdMsr) begin
        next_state.ch[c].modem = 1'b0;
      end

      // xoff or special character
      // RULE20: xoff flag
      if (srcIn[c].xoffSeen || srcIn[c].specialSeen) begin
        next_state.ch[c].xoff    = 1'b1;
        next_state.ch[c].special = srcIn[c].specialSeen;
      end else if (rdIdent || srcIn[c].xonSeen
                   || (state.ch[c].special && srcIn[c].charSeen)) begin
        next_state.ch[c].xoff    = 1'b0;
        next_state.ch[c].special = 1'b0;
      end

      // cts pin synchroniser and edge
      next_state.ch[c].ctsMeta = ctsPin[c];
      next_state.ch[c].ctsSync = state.ch[c].ctsMeta;
      next_state.ch[c].ctsPrev = state.ch[c].ctsSync;
      next_state.ch[c].rtsPrev = srcIn[c].rtsOut;
      ctsRise = state.ch[c].ctsSync & ~state.ch[c].ctsPrev & srcIn[c].autoCts;
      rtsRise = srcIn[c].rtsOut & ~state.ch[c].rtsPrev & srcIn[c].autoRts;

      // RULE21: cts rising flag
      if (ctsRise) begin
        next_state.ch[c].cts = 1'b1;
      end else if (rdIdent || rdMsr) begin
        next_state.ch[c].cts = 1'b0;
      end
      // RULE22: rts rising flag
      if (rtsRise) begin
        next_state.ch[c].rts = 1'b1;
      end else if (rdIdent || rdMsr) begin
        next_state.ch[c].rts = 1'b0;
      end

      // each channel drives its own output
      // RULE24: irq from pending
      // RULE27: per-channel output
      next_state.ch[c].irq = |pend[c];
    end

    // read data captured in the first cycle and held for the answer
    // RULE2: snapshot on read
    // RULE3: held during access
    if (first && avsRead) begin
      next_state.rdata = 8'h00;
      if (aligned) begin
        case (idx)
          uart_irq_pkg::IDX_RXBUF: next_state.rdata = srcIn[selCh].rxData;
          uart_irq_pkg::IDX_IER:   next_state.rdata = state.ch[selCh].interrupt_enable_reg;
          uart_irq_pkg::IDX_IDENT: next_state.rdata = identNow[selCh];
          uart_irq_pkg::IDX_EFR:   next_state.rdata = state.ch[selCh].enhanced_feature_reg;
          uart_irq_pkg::IDX_LSR:   next_state.rdata = srcIn[selCh].lineStatus;
          uart_irq_pkg::IDX_MSR:   next_state.rdata = srcIn[selCh].modemStatus;
          default:                 next_state.rdata = 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      for (int c = 0; c < uart_irq_pkg::NUM_CHAN; c++) begin
        state.ch[c].interrupt_enable_reg <= uart_irq_pkg::IER_RST;
        state.ch[c].enhanced_feature_reg <= uart_irq_pkg::EFR_RST;
      end
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : gChk
    // read answer equals the value seen at the first cycle
    property p_freeze;
      @(posedge sys_clk) disable iff (!rst_n)
      (first && avsRead && aligned && idx == uart_irq_pkg::IDX_IDENT && selCh == g)
      |=> (avsReaddata[7:0] == $past(identNow[g])) && !avsWaitrequest;
    endproperty
    a_freeze: assert property (p_freeze) else $error("ident read not frozen"); // RULE2

    // after a control write the status bits follow its fifo enable bit
    property p_fifo;
      @(posedge sys_clk) disable iff (!rst_n)
      (done && avsWrite && avsByteenable[0] && aligned && selCh == g
       && idx == uart_irq_pkg::IDX_IDENT)
      |=> identNow[g][7:6] == {2{$past(avsWritedata[0])}};
    endproperty
    a_fifo: assert property (p_fifo) else $error("fifo bits wrong"); // RULE4

    property p_none;
      @(posedge sys_clk) disable iff (!rst_n)
      (pend[g] == 7'h00) == (identNow[g][5:0] == 6'h01);
    endproperty
    a_none: assert property (p_none) else $error("idle code mismatch"); // RULE7

    property p_line;
      @(posedge sys_clk) disable iff (!rst_n)
      pend[g][0] |-> identNow[g][5:0] == 6'h06;
    endproperty
    a_line: assert property (p_line) else $error("line not top"); // RULE8

    property p_tout;
      @(posedge sys_clk) disable iff (!rst_n)
      (srcIn[g].rxTimeout && state.ch[g].interrupt_enable_reg[0] && !pend[g][0])
      |=> identNow[g][5:0] == 6'h0c;
    endproperty
    a_tout: assert property (p_tout) else $error("time-out not shown"); // RULE17

    property p_modem;
      @(posedge sys_clk) disable iff (!rst_n)
      (state.ch[g].modem && !(done && avsRead && idx == uart_irq_pkg::IDX_MSR))
      |=> state.ch[g].modem;
    endproperty
    a_modem: assert property (p_modem) else $error("modem flag lost"); // RULE19

    property p_mask;
      @(posedge sys_clk) disable iff (!rst_n)
      (state.ch[g].interrupt_enable_reg == 8'h00) |-> identNow[g][0] ##1 !irqOutput[g];
    endproperty
    a_mask: assert property (p_mask) else $error("masked source active"); // RULE23

    property p_irq;
      @(posedge sys_clk) disable iff (!rst_n)
      (pend[g] != 7'h00) |=> irqOutput[g];
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised"); // RULE24

    property p_enh;
      @(posedge sys_clk) disable iff (!rst_n)
      !state.ch[g].enhanced_feature_reg[4] |-> identNow[g][5:4] == 2'h0;
    endproperty
    a_enh: assert property (p_enh) else $error("enhanced source without enable"); // RULE25

    // a holding register write drops the empty flag when no rise competes
    property p_thre;
      @(posedge sys_clk) disable iff (!rst_n)
      (done && avsWrite && avsByteenable[0] && aligned && selCh == g
       && idx == uart_irq_pkg::IDX_RXBUF && state.ch[g].txPrev)
      |=> !state.ch[g].thre;
    endproperty
    a_thre: assert property (p_thre) else $error("empty flag kept after write"); // RULE18

    // xon clears the xoff flag unless a new xoff or special character lands
    property p_xon;
      @(posedge sys_clk) disable iff (!rst_n)
      (srcIn[g].xonSeen && !srcIn[g].xoffSeen && !srcIn[g].specialSeen)
      |=> !state.ch[g].xoff;
    endproperty
    a_xon: assert property (p_xon) else $error("xon left xoff flag set"); // RULE20

    // trigger level shows data ready when nothing higher pends
    property p_trig;
      @(posedge sys_clk) disable iff (!rst_n)
      (srcIn[g].rxTrig && state.ch[g].interrupt_enable_reg[0] && pend[g][1:0] == 2'h0)
      |-> identNow[g][5:0] == 6'h04;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger level not shown"); // RULE16
  end

endmodule : uart_interrupt_identify

// ---- include/uart_irq_pkg.sv ----
// constants and carriers of the dual-channel interrupt identification block
// ---------------------------------------------------------------------------
// Summary of operation
// RULE1: seven priority levels recorded per channel
// RULE2: identification read presents frozen top interrupt
// RULE3: events captured, shown value held during read
// RULE4: bits 7:6 show fifo enable state
// RULE5: bit 5 flags rts/cts rising edge
// RULE6: bit 4 flags xoff or special character
// RULE7: bit 0 high when nothing pending
// RULE8: line status errors, top priority, code 06
// RULE9: receive time-out, priority 2, code 0c
// RULE10: receive data ready, priority 3, code 04
// RULE11: transmit holding empty, priority 4, code 02
// RULE12: modem status change, priority 5, code 00
// RULE13: xoff or special character, priority 6, code 10
// RULE14: rts/cts rise priority 7 code 20; idle 01
// RULE15: line status read clears; source keeps flags
// RULE16: trigger pending until fifo below trigger
// RULE17: time-out raised by timer, cleared by buffer read
// RULE18: holding empty cleared by ident read or write
// RULE19: modem interrupt cleared only by modem read
// RULE20: xoff cleared by ident read, xon, next char
// RULE21: cts rise under auto cts, cleared by reads
// RULE22: rts rise under auto rts, cleared by reads
// RULE23: disabled source never pending nor drives irq
// RULE24: any enabled pending source drives irq
// RULE25: cts, rts, xoff enables need enhanced bit
// RULE26: highest pending shown, then next after clear
// RULE27: each channel has independent logic and irq
// ---------------------------------------------------------------------------
package uart_irq_pkg;
  localparam int NUM_CHAN = 2;              // serial channels
  // register indexes, byte address = chan*32 + index*4
  localparam logic [2:0] IDX_RXBUF = 3'h0;  // rx_buffer_reg / tx_holding_reg
  localparam logic [2:0] IDX_IER   = 3'h1;  // interrupt_enable_reg
  localparam logic [2:0] IDX_IDENT = 3'h2;  // interrupt_ident / fifo_control_reg
  localparam logic [2:0] IDX_EFR   = 3'h3;  // enhanced_feature_reg
  localparam logic [2:0] IDX_LSR   = 3'h5;  // line_status_reg
  localparam logic [2:0] IDX_MSR   = 3'h6;  // modem_status_reg
  // identification codes, bits 5:0
  localparam logic [5:0] ID_LINE = 6'h06;
  localparam logic [5:0] ID_TOUT = 6'h0c;
  localparam logic [5:0] ID_RXDV = 6'h04;
  localparam logic [5:0] ID_THRE = 6'h02;
  localparam logic [5:0] ID_MODM = 6'h00;
  localparam logic [5:0] ID_XOFF = 6'h10;
  localparam logic [5:0] ID_FLOW = 6'h20;
  localparam logic [5:0] ID_NONE = 6'h01;
  localparam logic [1:0] FIFO_ON  = 2'h3;   // bits 7:6 with fifos on
  localparam logic [1:0] FIFO_OFF = 2'h0;   // bits 7:6 with fifos off
  // enable bit positions
  localparam int IER_RXDV = 0;
  localparam int IER_THRE = 1;
  localparam int IER_LINE = 2;
  localparam int IER_MODM = 3;
  localparam int IER_XOFF = 5;
  localparam int IER_RTS  = 6;
  localparam int IER_CTS  = 7;
  localparam int EFR_ENH  = 4;              // enhanced function enable
  localparam int FCR_FIFO = 0;              // fifo enable in control write
  localparam logic [7:0] IER_RST = 8'h00;   // enables after reset
  localparam logic [7:0] EFR_RST = 8'h00;   // enhanced bits after reset

  // per-channel inputs from the source generators (same clock)
  typedef struct packed {
    logic [7:0] lineStatus;   // error bits 4:1 held by receiver
    logic [7:0] modemStatus;  // delta bits 3:0
    logic [7:0] rxData;       // receive buffer head
    logic       rxTrig;       // fill count at or above trigger
    logic       rxTimeout;    // one-cycle time-out pulse
    logic       txEmpty;      // holding register empty level
    logic       xoffSeen;     // xoff received pulse
    logic       specialSeen;  // special character pulse
    logic       xonSeen;      // xon received pulse
    logic       charSeen;     // any character received pulse
    logic       rtsOut;       // rts output level
    logic       autoCts;      // auto cts active
    logic       autoRts;      // auto rts active
  } chanSrc_s;

  // per-channel state
  typedef struct packed {
    logic [7:0] interrupt_enable_reg;
    logic [7:0] enhanced_feature_reg;
    logic       fifoOn;
    logic       lineAck;
    logic [3:0] errPrev;
    logic       tout;
    logic       thre;
    logic       txPrev;
    logic       modem;
    logic       xoff;
    logic       special;
    logic       cts;
    logic       rts;
    logic       ctsMeta;
    logic       ctsSync;
    logic       ctsPrev;
    logic       rtsPrev;
    logic       irq;
  } chan_s;
endpackage : uart_irq_pkg
